//--- core/dmem_cfg.svh
// Address map, reset values and response codes of the data memory unit
`ifndef DMEM_CFG_SVH
`define DMEM_CFG_SVH

`define LOC_PORT_A    8'h00
`define LOC_SHORT_PTR 8'h01
`define LOC_PORT_B    8'h02
`define LOC_B_LOW     8'h03
`define LOC_B_HIGH    8'h04
`define LOC_PORT_C    8'h0C
`define LOC_C_LOW     8'h0D
`define LOC_C_HIGH    8'h0E
`define LOC_FLASH_A   8'h28
`define LOC_FLASH_B   8'h29
`define LOC_EEPROM    8'h40
`define LOC_RAM_BASE  8'h80
`define LOC_SINE_END  8'hBF

`define SEC_SHORT     2'h0
`define SEC_FLASH     2'h1
`define SEC_SINE      2'h2
`define SEC_GP_A      2'h0
`define SEC_GP_B      2'h3

`define BANK_GP_A     2'h0
`define BANK_GP_B     2'h1
`define BANK_SINE     2'h2

`define RAM_DEPTH     320
`define RAM_AW        9

`define IDX_MSB       11
`define IDX_LSB       2

`define PTR_RST       8'h00
`define ZERO_BYTE     8'h00
`define RDATA_PAD     24'h000000
`define RESP_OKAY     2'h0

`endif

//--- core/dmem_pkg.sv
// Types shared by the data memory addressing unit
package dmem_pkg;

  typedef enum logic [0:0] {
    W_IDLE = 1'b0,
    W_RESP = 1'b1
  } wr_state_t;

  typedef enum logic [0:0] {
    R_IDLE = 1'b0,
    R_DATA = 1'b1
  } rd_state_t;

  typedef enum logic [1:0] {
    RG_ZERO = 2'b00,
    RG_RAM  = 2'b01,
    RG_SFR  = 2'b10
  } region_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic [2:0]  awprot;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic [2:0]  arprot;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic [7:0] short_ptr;
    logic [7:0] b_low;
    logic [7:0] b_high;
    logic [7:0] c_low;
    logic [7:0] c_high;
  } ptr_set_t;

  typedef struct packed {
    wr_state_t  wst;
    rd_state_t  rdst;
    logic       aw_have;
    logic       w_have;
    logic [9:0] waddr;
    logic [7:0] wdata;
    logic       wen;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    ptr_set_t   ptr;
    logic [7:0] eeprom_control;
    logic [7:0] flash_control_a;
    logic [7:0] flash_control_b;
  } state_t;

endpackage

//--- core/sector_ram.sv
// Byte-wide storage for the general purpose and sine pattern areas
`timescale 1ns/1ps

module sector_ram #(
  parameter int DEPTH = 320,
  parameter int AW    = 9,
  parameter int DW    = 8
) (
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  // Contents are not reset, as with the real RAM
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Out-of-range indices only occur for zero and special register regions, muxed off upstream
  assign rdata = mem[raddr];

endmodule

//--- core/data_memory_indirect_addressing.sv
// Data memory addressing unit with indirect ports, behind AXI4-Lite
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "dmem_cfg.svh"

// What this block does
// - Port locations redirect the access to the address held in their pointer.
// - The first port with the short pointer always lands in sector 0.
// - Second and third ports use high pointer as sector, low as location.
// - Port locations have no storage: read 00H, writes are dropped.
// - All five pointers are plain read-write storage like any register.
// - Unused special register locations read back as 00H.
// - Extended direct addresses reach every location of every sector.
// - Special registers seen everywhere; eeprom and flash controls only sector 1.
// - RAM at 80H-FFH of sectors 0 and 3; sine memory 80H-BFH of sector 2.
module data_memory_indirect_addressing #(
  parameter int RAM_DEPTH = `RAM_DEPTH,
  parameter int RAM_AW    = `RAM_AW
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire dmem_pkg::axi_req_t s_axi_req,
  output dmem_pkg::axi_rsp_t      s_axi_rsp,
  output dmem_pkg::ptr_set_t      pointers
);

  import dmem_pkg::*;

  localparam state_t STATE_RST = '{
    wst:             W_IDLE,
    rdst:            R_IDLE,
    aw_have:         1'b0,
    w_have:          1'b0,
    waddr:           10'h000,
    wdata:           `ZERO_BYTE,
    wen:             1'b0,
    awready:         1'b1,
    wready:          1'b1,
    bvalid:          1'b0,
    arready:         1'b1,
    rvalid:          1'b0,
    rdata:           `ZERO_BYTE,
    ptr:             '{`PTR_RST, `PTR_RST, `PTR_RST, `PTR_RST, `PTR_RST},
    eeprom_control:  `PTR_RST,
    flash_control_a: `PTR_RST,
    flash_control_b: `PTR_RST
  };

  state_t            state_ff;
  state_t            nxt_state;

  logic [9:0]        rd_ea;
  region_t           rd_rg;
  logic [7:0]        rd_byte;
  logic [9:0]        wr_ea;
  region_t           wr_rg;
  logic [RAM_AW-1:0] ram_raddr;
  logic [RAM_AW-1:0] ram_waddr;
  logic [7:0]        ram_rdata;
  logic              ram_we;

  // Map a location seen by an instruction onto the location really used
  function automatic logic [9:0] resolve(input logic [9:0] a,
                                         input ptr_set_t   p);
    logic [7:0] loc;
    loc = a[7:0];
    unique case (loc)
      `LOC_PORT_A: resolve = {`SEC_SHORT, p.short_ptr};
      `LOC_PORT_B: resolve = {p.b_high[1:0], p.b_low};
      `LOC_PORT_C: resolve = {p.c_high[1:0], p.c_low};
      default:     resolve = a;
    endcase
  endfunction

  // What kind of storage, if any, stands behind a resolved address
  function automatic region_t classify(input logic [9:0] ea);
    logic [1:0] sec;
    logic [7:0] loc;
    sec = ea[9:8];
    loc = ea[7:0];
    classify = RG_ZERO;
    if (loc >= `LOC_RAM_BASE) begin
      if (sec == `SEC_GP_A || sec == `SEC_GP_B) begin
        classify = RG_RAM;
      end else if (sec == `SEC_SINE && loc <= `LOC_SINE_END) begin
        classify = RG_RAM;
      end
    end else begin
      unique case (loc)
        `LOC_SHORT_PTR, `LOC_B_LOW, `LOC_B_HIGH,
        `LOC_C_LOW, `LOC_C_HIGH: begin
          classify = RG_SFR;
        end
        `LOC_FLASH_A, `LOC_FLASH_B, `LOC_EEPROM: begin
          if (sec == `SEC_FLASH) begin
            classify = RG_SFR;
          end
        end
        // Port locations and all others hold nothing here
        default: classify = RG_ZERO;
      endcase
    end
  endfunction

  // Pack the three RAM areas into one contiguous array
  function automatic logic [RAM_AW-1:0] ram_index(input logic [9:0] ea);
    logic [1:0] bank;
    unique case (ea[9:8])
      `SEC_GP_A: bank = `BANK_GP_A;
      `SEC_GP_B: bank = `BANK_GP_B;
      default:   bank = `BANK_SINE;
    endcase
    ram_index = RAM_AW'({bank, ea[6:0]});
  endfunction

  function automatic logic [7:0] sfr_read(input logic [7:0] loc,
                                          input state_t   s);
    unique case (loc)
      `LOC_SHORT_PTR: sfr_read = s.ptr.short_ptr;
      `LOC_B_LOW:     sfr_read = s.ptr.b_low;
      `LOC_B_HIGH:    sfr_read = s.ptr.b_high;
      `LOC_C_LOW:     sfr_read = s.ptr.c_low;
      `LOC_C_HIGH:    sfr_read = s.ptr.c_high;
      `LOC_EEPROM:    sfr_read = s.eeprom_control;
      `LOC_FLASH_A:   sfr_read = s.flash_control_a;
      `LOC_FLASH_B:   sfr_read = s.flash_control_b;
      default:        sfr_read = `ZERO_BYTE;
    endcase
  endfunction

  // Read side resolves straight from the offered address
  assign rd_ea     = resolve(s_axi_req.araddr[`IDX_MSB:`IDX_LSB],
                             state_ff.ptr);
  assign rd_rg     = classify(rd_ea);
  assign ram_raddr = ram_index(rd_ea);

  always_comb begin
    unique case (rd_rg)
      RG_RAM:  rd_byte = ram_rdata;
      RG_SFR:  rd_byte = sfr_read(rd_ea[7:0], state_ff);
      default: rd_byte = `ZERO_BYTE;
    endcase
  end

  // Write side resolves the held address, pointers as they stand now
  assign wr_ea     = resolve(state_ff.waddr, state_ff.ptr);
  assign wr_rg     = classify(wr_ea);
  assign ram_waddr = ram_index(wr_ea);

  sector_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (RAM_AW),
    .DW    (8)
  ) u_ram (
    .core_clk (core_clk),
    .we       (ram_we),
    .waddr    (ram_waddr),
    .wdata    (state_ff.wdata),
    .raddr    (ram_raddr),
    .rdata    (ram_rdata)
  );

  always_comb begin
    nxt_state = state_ff;
    ram_we    = 1'b0;

    // Write channel: address and data accepted in either order
    unique case (state_ff.wst)
      W_IDLE: begin
        if (state_ff.aw_have && state_ff.w_have) begin
          // Strobe off, port target or empty slot: dropped, still OKAY
          if (state_ff.wen) begin
            unique case (wr_rg)
              RG_RAM: ram_we = 1'b1;
              RG_SFR: begin
                unique case (wr_ea[7:0])
                  `LOC_SHORT_PTR: begin
                    nxt_state.ptr.short_ptr = state_ff.wdata;
                  end
                  `LOC_B_LOW: begin
                    nxt_state.ptr.b_low = state_ff.wdata;
                  end
                  `LOC_B_HIGH: begin
                    nxt_state.ptr.b_high = state_ff.wdata;
                  end
                  `LOC_C_LOW: begin
                    nxt_state.ptr.c_low = state_ff.wdata;
                  end
                  `LOC_C_HIGH: begin
                    nxt_state.ptr.c_high = state_ff.wdata;
                  end
                  `LOC_EEPROM: begin
                    nxt_state.eeprom_control = state_ff.wdata;
                  end
                  `LOC_FLASH_A: begin
                    nxt_state.flash_control_a = state_ff.wdata;
                  end
                  `LOC_FLASH_B: begin
                    nxt_state.flash_control_b = state_ff.wdata;
                  end
                  default: begin
                  end
                endcase
              end
              default: begin
              end
            endcase
          end
          nxt_state.aw_have = 1'b0;
          nxt_state.w_have  = 1'b0;
          nxt_state.bvalid  = 1'b1;
          nxt_state.wst     = W_RESP;
        end else begin
          if (s_axi_req.awvalid && state_ff.awready) begin
            nxt_state.aw_have = 1'b1;
            nxt_state.awready = 1'b0;
            nxt_state.waddr   = s_axi_req.awaddr[`IDX_MSB:`IDX_LSB];
          end
          if (s_axi_req.wvalid && state_ff.wready) begin
            nxt_state.w_have = 1'b1;
            nxt_state.wready = 1'b0;
            nxt_state.wdata  = s_axi_req.wdata[7:0];
            nxt_state.wen    = s_axi_req.wstrb[0];
          end
        end
      end
      W_RESP: begin
        if (s_axi_req.bready) begin
          nxt_state.bvalid  = 1'b0;
          nxt_state.awready = 1'b1;
          nxt_state.wready  = 1'b1;
          nxt_state.wst     = W_IDLE;
        end
      end
    endcase

    // Read channel: data sampled on the address handshake edge
    unique case (state_ff.rdst)
      R_IDLE: begin
        if (s_axi_req.arvalid && state_ff.arready) begin
          nxt_state.rdata   = rd_byte;
          nxt_state.rvalid  = 1'b1;
          nxt_state.arready = 1'b0;
          nxt_state.rdst    = R_DATA;
        end
      end
      R_DATA: begin
        if (s_axi_req.rready) begin
          nxt_state.rvalid  = 1'b0;
          nxt_state.arready = 1'b1;
          nxt_state.rdst    = R_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every field below is a flip-flop or a constant
  assign s_axi_rsp.awready = state_ff.awready;
  assign s_axi_rsp.wready  = state_ff.wready;
  assign s_axi_rsp.bvalid  = state_ff.bvalid;
  assign s_axi_rsp.bresp   = `RESP_OKAY;
  assign s_axi_rsp.arready = state_ff.arready;
  assign s_axi_rsp.rvalid  = state_ff.rvalid;
  assign s_axi_rsp.rdata   = {`RDATA_PAD, state_ff.rdata};
  assign s_axi_rsp.rresp   = `RESP_OKAY;
  assign pointers          = state_ff.ptr;

endmodule

//--- tb/data_memory_indirect_addressing_sva.sv
// Port-level checks for the data memory addressing unit
`timescale 1ns/1ps
module addr_unit_chk (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire dmem_pkg::axi_req_t s_axi_req,
  input wire dmem_pkg::axi_rsp_t s_axi_rsp,
  input wire dmem_pkg::ptr_set_t pointers
);
  import dmem_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       ar_hs;
  logic       aw_w_hs;
  logic [7:0] ar_loc;
  logic [1:0] ar_sec;
  assign ar_hs   = s_axi_req.arvalid && s_axi_rsp.arready;
  assign aw_w_hs = s_axi_req.awvalid && s_axi_rsp.awready &&
                   s_axi_req.wvalid && s_axi_rsp.wready;
  assign ar_loc  = s_axi_req.araddr[9:2];
  assign ar_sec  = s_axi_req.araddr[11:10];

  property p_rd_lat;
    ar_hs |=> s_axi_rsp.rvalid;
  endproperty
  property p_rd_hold;
    s_axi_rsp.rvalid && !s_axi_req.rready |=>
      s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata);
  endproperty
  property p_r_shape;
    s_axi_rsp.rvalid |-> !s_axi_rsp.arready && s_axi_rsp.rresp == 2'h0 &&
      s_axi_rsp.rdata[31:8] == 24'h000000;
  endproperty
  property p_wr_lat;
    aw_w_hs |=> !s_axi_rsp.bvalid ##1 s_axi_rsp.bvalid;
  endproperty
  property p_b_done;
    s_axi_rsp.bvalid && s_axi_req.bready |=>
      !s_axi_rsp.bvalid && s_axi_rsp.awready && s_axi_rsp.wready;
  endproperty
  // Pointers only move when a write completes
  property p_ptr_store;
    $changed(pointers) |-> $rose(s_axi_rsp.bvalid);
  endproperty
  property p_port_zero;
    ar_hs && ar_loc == 8'h00 && pointers.short_ptr inside {8'h00, 8'h02, 8'h0C}
      |=> s_axi_rsp.rdata[7:0] == 8'h00;
  endproperty
  property p_unused;
    ar_hs && ar_loc inside {[8'h10:8'h27]} |=> s_axi_rsp.rdata[7:0] == 8'h00;
  endproperty
  property p_sec1_only;
    ar_hs && ar_sec != 2'h1 && ar_loc inside {8'h28, 8'h29, 8'h40}
      |=> s_axi_rsp.rdata[7:0] == 8'h00;
  endproperty

  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_r_shape: assert property (p_r_shape) else $error("read malformed");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer off");
  a_b_done: assert property (p_b_done) else $error("write not freed");
  a_ptr_store: assert property (p_ptr_store) else $error("ptr moved");
  a_port_zero: assert property (p_port_zero) else $error("port not 0");
  a_unused: assert property (p_unused) else $error("unused not 0");
  a_sec1_only: assert property (p_sec1_only) else $error("ctl leak");

  c_port_rd: cover property (ar_hs && ar_loc == 8'h00);
  c_write: cover property (aw_w_hs);
  c_b_done: cover property (s_axi_rsp.bvalid && s_axi_req.bready);
endmodule

bind data_memory_indirect_addressing addr_unit_chk u_chk (
  .core_clk  (core_clk),
  .rst       (rst),
  .s_axi_req (s_axi_req),
  .s_axi_rsp (s_axi_rsp),
  .pointers  (pointers)
);

//--- tb/data_memory_indirect_addressing_tb.sv
// Self-checking bench for the data memory addressing unit
`timescale 1ns/1ps
module data_memory_indirect_addressing_tb;
  import dmem_pkg::*;
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  axi_req_t    req = '0;
  axi_rsp_t    rsp;
  ptr_set_t    ptr;
  int          n_mismatch = 0;
  int          tests_run = 0;
  logic [19:0] expq[$];
  logic [7:0]  d;
  logic [7:0]  e;
  logic [7:0]  dv[9];
  logic [7:0]  pl[5] = '{8'h01, 8'h03, 8'h04, 8'h0D, 8'h0E};
  logic [7:0]  cl[3] = '{8'h28, 8'h29, 8'h40};
  // Keep flag, sector, location
  logic [10:0] rt[9] = '{11'h480, 11'h4FF, 11'h780, 11'h7FF, 11'h680,
                         11'h6BF, 11'h2C0, 11'h180, 11'h1FF};

  data_memory_indirect_addressing DUT (
    .core_clk  (core_clk),
    .rst       (rst),
    .s_axi_req (req),
    .s_axi_rsp (rsp),
    .pointers  (ptr)
  );

  always #5 core_clk = ~core_clk;

  function automatic logic [11:0] ad(logic [1:0] s, logic [7:0] l);
    return {s, l, 2'h0};
  endfunction

  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Starts one edge late so a release is never re-raised in the same step
  task automatic wr(logic [11:0] a, logic [7:0] v);
    bit pa;
    bit pw;
    bit ra;
    bit rw;
    bit rb;
    int n;
    @(posedge core_clk);
    req.awvalid <= 1'h1;
    req.awaddr  <= a;
    req.wvalid  <= 1'h1;
    req.wdata   <= {24'h000000, v};
    req.bready  <= 1'h1;
    pa = 1;
    pw = 1;
    // Ready is read mid-cycle, settled, for the edge that follows
    for (n = 0; n < 50 && (pa || pw); n++) begin
      @(negedge core_clk);
      ra = rsp.awready;
      rw = rsp.wready;
      @(posedge core_clk);
      if (ra) pa = 0;
      if (rw) pw = 0;
      req.awvalid <= pa;
      req.wvalid  <= pw;
    end
    rb = 0;
    for (n = 0; n < 50 && !rb; n++) begin
      @(negedge core_clk);
      rb = rsp.bvalid;
      @(posedge core_clk);
    end
    req.bready <= 1'h0;
  endtask

  task automatic rd(logic [11:0] a, logic [7:0] v);
    bit p;
    bit ra;
    bit rv;
    int n;
    @(posedge core_clk);
    expq.push_back({a, v});
    req.arvalid <= 1'h1;
    req.araddr  <= a;
    req.rready  <= 1'h1;
    p = 1;
    for (n = 0; n < 50 && p; n++) begin
      @(negedge core_clk);
      ra = rsp.arready;
      @(posedge core_clk);
      if (ra) p = 0;
      req.arvalid <= p;
    end
    rv = 0;
    for (n = 0; n < 50 && !rv; n++) begin
      @(negedge core_clk);
      rv = rsp.rvalid;
      @(posedge core_clk);
    end
    req.rready <= 1'h0;
  endtask

  // Mid-cycle look: rvalid stands exactly one cycle with rready held
  always @(negedge core_clk) begin
    logic [19:0] q;
    if (!rst && rsp.rvalid === 1'h1 && req.rready && expq.size() > 0) begin
      q = expq.pop_front();
      chk($sformatf("rdata %h", q[19:8]), rsp.rdata[7:0], q[7:0]);
    end
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    req.wstrb = 4'hF;
    void'($urandom(34935));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    foreach (pl[i]) rd(ad(2'h3, pl[i]), 8'h00);
    foreach (pl[i]) begin
      d = 8'($urandom);
      wr(ad(2'(i), pl[i]), d);
      rd(ad(2'(i + 1), pl[i]), d);
    end
    $display("test pointers done");
    // Write all first so sector aliasing shows on read back
    foreach (rt[i]) begin
      dv[i] = 8'($urandom);
      wr(ad(rt[i][9:8], rt[i][7:0]), dv[i]);
    end
    foreach (rt[i]) begin
      e = rt[i][10] ? dv[i] : 8'h00;
      rd(ad(rt[i][9:8], rt[i][7:0]), e);
    end
    $display("test direct done");
    wr(ad(2'h0, 8'h01), 8'h85);
    chk("short_ptr", ptr.short_ptr, 8'h85);
    e = 8'($urandom);
    wr(ad(2'h3, 8'h85), e);
    d = 8'($urandom);
    wr(ad(2'h3, 8'h00), d);
    rd(ad(2'h0, 8'h85), d);
    rd(ad(2'h2, 8'h00), d);
    rd(ad(2'h3, 8'h85), e);
    wr(ad(2'h0, 8'h04), 8'hFB);
    wr(ad(2'h0, 8'h03), 8'hA0);
    d = 8'($urandom);
    wr(ad(2'h1, 8'h02), d);
    rd(ad(2'h3, 8'hA0), d);
    rd(ad(2'h2, 8'h04), 8'hFB);
    wr(ad(2'h0, 8'h0E), 8'h02);
    wr(ad(2'h0, 8'h0D), 8'h90);
    wr(ad(2'h2, 8'h0C), d);
    rd(ad(2'h2, 8'h90), d);
    rd(ad(2'h0, 8'h0C), d);
    $display("test ports done");
    wr(ad(2'h0, 8'h01), 8'h0C);
    wr(ad(2'h0, 8'h00), 8'h5A);
    rd(ad(2'h0, 8'h00), 8'h00);
    chk("c_low", ptr.c_low, 8'h90);
    rd(ad(2'h0, 8'h0C), d);
    $display("test no storage done");
    foreach (cl[i]) begin
      d = 8'($urandom);
      wr(ad(2'h1, cl[i]), d);
      wr(ad(2'h2, cl[i]), ~d);
      rd(ad(2'h1, cl[i]), d);
      rd(ad(2'h3, cl[i]), 8'h00);
      e = 8'h10 + 8'($urandom % 24);
      wr(ad(2'(i), e), d);
      rd(ad(2'(i), e), 8'h00);
    end
    $display("test sector one done");
    final_report();
  end
endmodule
